// *** pad_board.sv ***
/*
  Board model for the four pads: pull-ups plus an external driver.
  Assumes an enable from the module means the module drives the pad.
*/
`timescale 1ns/100ps
module pad_board (
  // Module side
  input wire logic [3:0] pin_out_i,
  input wire logic [3:0] pin_oe_i,
  // External driver
  input wire logic [3:0] ext_en_i,
  input wire logic [3:0] ext_val_i,
  // Resolved pad level
  output logic [3:0] pad_o
);
  // Module drive wins, then the external driver; a pad neither drives floats up so open drain reads high
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
    end
  end
endmodule

// *** pin_driver.sv ***
/*
  One multipurpose pin: two-flop input synchroniser and registered drive
  logic for the eight drive-state codes.
  Assumes the pad resolves the wire from pin_out_o and pin_oe_o.
*/
`timescale 1ns/100ps
module pin_driver
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control from the mux
  input wire logic [2:0] drive_state_i,
  input wire logic value_i,
  input wire logic force_low_i,
  // Pad side
  input wire logic pin_in_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  // Synchronised pin level
  output logic synced_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic out;
    logic oe;
  } drv_s;

  drv_s q_r;
  drv_s q_nxt;

  // Next state: synchroniser and drive decode
  always_comb begin
    q_nxt = q_r;
    q_nxt.sync1 = pin_in_i; // [R11]
    q_nxt.sync2 = q_r.sync1; // [R11]
    q_nxt.out = 1'b0;
    q_nxt.oe = 1'b0;
    unique case (drive_state_i) // [R1]
      DRV_TRISTATE, DRV_INPUT: begin
        q_nxt.oe = 1'b0;
      end
      DRV_OPEN_DRAIN: begin
        q_nxt.oe = force_low_i | ~value_i;
      end
      DRV_PUSH_PULL: begin
        q_nxt.oe = 1'b1;
        q_nxt.out = value_i & ~force_low_i;
      end
      DRV_RESERVED, DRV_GROUND: begin
        q_nxt.oe = 1'b1; // [R12]
      end
      DRV_INV_OPEN_DRAIN: begin
        q_nxt.oe = force_low_i | value_i; // [R2]
      end
      DRV_INV_PUSH_PULL: begin
        q_nxt.oe = 1'b1;
        q_nxt.out = ~value_i & ~force_low_i; // [R2]
      end
    endcase
    if (!reset_n_i) begin
      q_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    q_r <= q_nxt;
  end

  assign pin_out_o = q_r.out;
  assign pin_oe_o = q_r.oe;
  assign synced_o = q_r.sync2;
endmodule

// *** pin_mux.sv ***
/*
  Multipurpose pin mux top: AXI4-Lite register file, pump-voltage monitor,
  combined lock indication, source routing per pin and interrupt logic.
  Assumes all internal source inputs are on clk_i; pins are asynchronous.
*/
// What this block does
// R1: Three-bit drive state per pin, eight codes.
// R2: Codes five and six invert the routed signal.
// R3: Six-bit select per pin; reserved codes listed.
// R4: Code ten outputs lock AND monitor good.
// R5: Codes eleven to thirteen: lock, good, high.
// R6: Code fourteen outputs pump voltage too low.
// R7: Codes twenty-eight, twenty-nine: fastlock, pump gain.
// R8: Code thirty flag zero; 32-34 triggers A-C.
// R9: Codes 31, 35-38: flag, dividers, pulses, done.
// R10: Lock low when pump below low threshold.
// R11: Pin inputs pass a two-flop synchroniser.
// R12: Reserved drive codes drive the pin low; reserved selects do too, except in tristate and input.
`timescale 1ns/100ps
module pin_mux
  import pin_mux_pkg::*;
#(
  parameter int PUMP_W = 6
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Lock and pump monitor inputs
  input wire logic digital_phase_lock_i,
  input wire logic [PUMP_W-1:0] pump_voltage_monitor_i,
  // Internal sources
  input wire logic readback_data_i,
  input wire logic comparator_zero_i,
  input wire logic comparator_one_i,
  input wire logic ramp_limit_exceeded_i,
  input wire logic ref_div_half_i,
  input wire logic ref_div_quarter_i,
  input wire logic fb_div_half_i,
  input wire logic fb_div_quarter_i,
  input wire logic comparator_zero_ramp_i,
  input wire logic comparator_one_ramp_i,
  input wire logic fastlock_active_i,
  input wire logic pump_gain_select_i,
  input wire logic ramp_flag_zero_i,
  input wire logic ramp_flag_one_i,
  input wire logic trigger_source_a_i,
  input wire logic trigger_source_b_i,
  input wire logic trigger_source_c_i,
  input wire logic ref_div_out_i,
  input wire logic pump_up_pulse_i,
  input wire logic pump_down_pulse_i,
  input wire logic sweep_repeat_counter_done_i,
  // Pads: index 0 trigger one, 1 trigger two, 2 keying, 3 mux out
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  // To internal consumers
  output logic [NUM_PINS-1:0] synced_pin_o,
  output logic combined_lock_indication_o,
  output logic irq_o
);
  // Thresholds are compared directly against the monitor code
  if (PUMP_W != THR_W) begin : g_bad_width
    $error("pin_mux: PUMP_W must equal the threshold width");
  end

  typedef struct packed {
    logic [NUM_PINS-1:0][CTL_W-1:0] ctl;
    logic [THR_W-1:0] thr_lo;
    logic [THR_W-1:0] thr_hi;
    logic [ST_W-1:0] sts;
    logic [ST_W-1:0] msk;
    logic aw_rdy;
    logic [ADDR_W-1:0] aw_addr;
    logic w_rdy;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic lock_q;
    logic lock_out;
    logic irq;
  } top_s;

  top_s q_r;
  top_s q_nxt;

  logic pump_low;
  logic pump_high;
  logic mon_good;
  logic lock;
  logic [63:0] src;
  logic [NUM_PINS-1:0] rsv_sel;
  logic [NUM_PINS-1:0] synced;
  logic [ST_W-1:0] events;

  // Pump monitor compares; lock is dropped while below the low threshold
  assign pump_low = pump_voltage_monitor_i < q_r.thr_lo; // [R10]
  assign pump_high = pump_voltage_monitor_i > q_r.thr_hi;
  assign mon_good = ~pump_low & ~pump_high;
  assign lock = digital_phase_lock_i & mon_good; // [R4] [R10]

  // Source table indexed by the select code; unlisted codes stay low
  always_comb begin
    src = '0;
    src[SEL_OUT_TRIG_ONE] = synced[PIN_TRIG_ONE]; // [R3] [R11]
    src[SEL_OUT_TRIG_TWO] = synced[PIN_TRIG_TWO]; // [R3]
    src[SEL_OUT_KEYING] = synced[PIN_KEYING]; // [R3]
    src[SEL_READBACK] = readback_data_i;
    src[SEL_COMPARATOR_ZERO] = comparator_zero_i;
    src[SEL_COMPARATOR_ONE] = comparator_one_i;
    src[SEL_LOCK] = lock; // [R4]
    src[SEL_DLD] = digital_phase_lock_i; // [R5]
    src[SEL_MON_GOOD] = mon_good; // [R5]
    src[SEL_MON_HIGH] = pump_high; // [R5]
    src[SEL_MON_LOW] = pump_low; // [R6]
    src[SEL_RAMP_LIMIT] = ramp_limit_exceeded_i;
    src[SEL_RDIV2] = ref_div_half_i;
    src[SEL_RDIV4] = ref_div_quarter_i;
    src[SEL_NDIV2] = fb_div_half_i;
    src[SEL_NDIV4] = fb_div_quarter_i;
    src[SEL_COMPARATOR_ZERO_RAMP] = comparator_zero_ramp_i;
    src[SEL_COMPARATOR_ONE_RAMP] = comparator_one_ramp_i;
    src[SEL_FASTLOCK] = fastlock_active_i; // [R7]
    src[SEL_PUMP_GAIN] = pump_gain_select_i; // [R7]
    src[SEL_FLAG0] = ramp_flag_zero_i; // [R8]
    src[SEL_FLAG1] = ramp_flag_one_i; // [R9]
    src[SEL_TRIG_A] = trigger_source_a_i; // [R8]
    src[SEL_TRIG_B] = trigger_source_b_i; // [R8]
    src[SEL_TRIG_C] = trigger_source_c_i; // [R8]
    src[SEL_RDIV] = ref_div_out_i; // [R9]
    src[SEL_PUMP_UP] = pump_up_pulse_i; // [R9]
    src[SEL_PUMP_DN] = pump_down_pulse_i; // [R9]
    src[SEL_CNT_DONE] = sweep_repeat_counter_done_i; // [R9]
  end

  // One driver per pin; reserved selects force an active low in every drive state except tristate and input
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [SEL_W-1:0] sel;
    assign sel = q_r.ctl[p][SEL_LSB +: SEL_W];
    assign rsv_sel[p] = (sel == 6'd20) || (sel == 6'd21) || (sel >= 6'd24 && sel <= 6'd27)
                        || (sel >= 6'(SEL_FIRST_RSV_HI)); // [R3] [R12]
    pin_driver u_drv (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .drive_state_i(q_r.ctl[p][DRV_LSB +: 3]),
      .value_i(src[sel]),
      .force_low_i(rsv_sel[p]),
      .pin_in_i(pin_in_i[p]),
      .pin_out_o(pin_out_o[p]),
      .pin_oe_o(pin_oe_o[p]),
      .synced_o(synced[p])
    );
  end

  // Events: lock edges and pump out of window
  always_comb begin
    events = '0;
    events[ST_LOCK_LOST] = q_r.lock_q & ~lock;
    events[ST_LOCK_GAINED] = ~q_r.lock_q & lock;
    events[ST_PUMP_LOW] = pump_low;
    events[ST_PUMP_HIGH] = pump_high;
  end

  // Register read view; bit 32 marks a mapped address
  function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = '0;
    r[32] = 1'b1;
    unique case (a[ADDR_W-1:2])
      IDX_TRIG_ONE_CTL: r[CTL_W-1:0] = q_r.ctl[PIN_TRIG_ONE];
      IDX_TRIG_TWO_CTL: r[CTL_W-1:0] = q_r.ctl[PIN_TRIG_TWO];
      IDX_KEYING_CTL: r[CTL_W-1:0] = q_r.ctl[PIN_KEYING];
      IDX_MULTIPURPOSE_OUT_PIN_CTL: r[CTL_W-1:0] = q_r.ctl[PIN_MULTIPURPOSE_OUT_PIN];
      IDX_THRESHOLD: begin
        r[THR_LO_LSB +: THR_W] = q_r.thr_lo;
        r[THR_HI_LSB +: THR_W] = q_r.thr_hi;
      end
      IDX_IRQ_STATUS: r[ST_W-1:0] = q_r.sts;
      IDX_IRQ_MASK: r[ST_W-1:0] = q_r.msk;
      IDX_MONITOR: r[8:0] = {synced, pump_low, pump_high, mon_good, digital_phase_lock_i, lock};
      default: r[32] = 1'b0;
    endcase
    return r;
  endfunction

  // Bus, register file and interrupt next state
  always_comb begin
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [32:0] cur;
    logic [ST_W-1:0] clr;
    logic [5:0] widx;
    wmask = {{8{q_r.w_strb[3]}}, {8{q_r.w_strb[2]}}, {8{q_r.w_strb[1]}}, {8{q_r.w_strb[0]}}};
    cur = reg_read(q_r.aw_addr);
    wval = (cur[31:0] & ~wmask) | (q_r.w_data & wmask);
    widx = q_r.aw_addr[ADDR_W-1:2];
    clr = '0;
    q_nxt = q_r;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid_i && q_r.aw_rdy) begin
      q_nxt.aw_addr = s_axi_awaddr_i;
      q_nxt.aw_rdy = 1'b0;
    end
    if (s_axi_wvalid_i && q_r.w_rdy) begin
      q_nxt.w_data = s_axi_wdata_i;
      q_nxt.w_strb = s_axi_wstrb_i;
      q_nxt.w_rdy = 1'b0;
    end
    // Perform the write once both halves are held
    if (!q_r.aw_rdy && !q_r.w_rdy && !q_r.bvalid) begin
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = cur[32] ? RESP_OKAY : RESP_SLVERR;
      unique case (widx)
        IDX_TRIG_ONE_CTL: q_nxt.ctl[PIN_TRIG_ONE] = wval[CTL_W-1:0]; // [R1] [R3]
        IDX_TRIG_TWO_CTL: q_nxt.ctl[PIN_TRIG_TWO] = wval[CTL_W-1:0];
        IDX_KEYING_CTL: q_nxt.ctl[PIN_KEYING] = wval[CTL_W-1:0];
        IDX_MULTIPURPOSE_OUT_PIN_CTL: q_nxt.ctl[PIN_MULTIPURPOSE_OUT_PIN] = wval[CTL_W-1:0];
        IDX_THRESHOLD: begin
          q_nxt.thr_lo = wval[THR_LO_LSB +: THR_W]; // [R10]
          q_nxt.thr_hi = wval[THR_HI_LSB +: THR_W];
        end
        IDX_IRQ_STATUS: clr = q_r.w_data[ST_W-1:0] & wmask[ST_W-1:0];
        IDX_IRQ_MASK: q_nxt.msk = wval[ST_W-1:0];
        default: clr = '0;
      endcase
    end
    // Response handshake frees both write channels again
    if (q_r.bvalid && s_axi_bready_i) begin
      q_nxt.bvalid = 1'b0;
      q_nxt.aw_rdy = 1'b1;
      q_nxt.w_rdy = 1'b1;
    end
    // Read: data registered on the same edge that takes the address
    if (s_axi_arvalid_i && q_r.ar_rdy) begin
      cur = reg_read(s_axi_araddr_i);
      q_nxt.rdata = cur[31:0];
      q_nxt.rresp = cur[32] ? RESP_OKAY : RESP_SLVERR;
      q_nxt.rvalid = 1'b1;
      q_nxt.ar_rdy = 1'b0;
    end
    if (q_r.rvalid && s_axi_rready_i) begin
      q_nxt.rvalid = 1'b0;
      q_nxt.ar_rdy = 1'b1;
    end
    // Sticky status: a set in the clearing cycle survives the clear
    q_nxt.sts = (q_r.sts & ~clr) | events;
    q_nxt.irq = |(q_nxt.sts & q_nxt.msk);
    q_nxt.lock_q = lock;
    q_nxt.lock_out = lock; // [R4] [R10]
    if (!reset_n_i) begin
      q_nxt = '0;
      q_nxt.ctl[PIN_TRIG_ONE] = CTL_RST_TRIG_ONE; // [R1]
      q_nxt.ctl[PIN_TRIG_TWO] = CTL_RST_TRIG_TWO;
      q_nxt.ctl[PIN_KEYING] = CTL_RST_KEYING;
      q_nxt.ctl[PIN_MULTIPURPOSE_OUT_PIN] = CTL_RST_MULTIPURPOSE_OUT_PIN;
      q_nxt.thr_lo = THR_LO_RST;
      q_nxt.thr_hi = THR_HI_RST;
      q_nxt.aw_rdy = 1'b1;
      q_nxt.w_rdy = 1'b1;
      q_nxt.ar_rdy = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    q_r <= q_nxt;
  end

  // Outputs straight from the state register
  assign s_axi_awready_o = q_r.aw_rdy;
  assign s_axi_wready_o = q_r.w_rdy;
  assign s_axi_bvalid_o = q_r.bvalid;
  assign s_axi_bresp_o = q_r.bresp;
  assign s_axi_arready_o = q_r.ar_rdy;
  assign s_axi_rvalid_o = q_r.rvalid;
  assign s_axi_rdata_o = q_r.rdata;
  assign s_axi_rresp_o = q_r.rresp;
  assign synced_pin_o = synced;
  assign combined_lock_indication_o = q_r.lock_out;
  assign irq_o = q_r.irq;
endmodule

// *** pin_mux_pkg.sv ***
/*
  Shared constants for the multipurpose pin mux: register indices, field
  positions, reset values, drive-state codes, selection codes, status bits.
  Assumes a 32-bit AXI4-Lite register bus with byte address = 4 * index.
*/
package pin_mux_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_TRIG_ONE_CTL = 6'h24;
  localparam logic [5:0] IDX_TRIG_TWO_CTL = 6'h25;
  localparam logic [5:0] IDX_KEYING_CTL = 6'h26;
  localparam logic [5:0] IDX_MULTIPURPOSE_OUT_PIN_CTL = 6'h27;
  localparam logic [5:0] IDX_THRESHOLD = 6'h28;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h29;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h2A;
  localparam logic [5:0] IDX_MONITOR = 6'h2B;
  localparam int ADDR_W = 8;
  localparam int NUM_PINS = 4;
  // Pin numbering inside vectors
  localparam int PIN_TRIG_ONE = 0;
  localparam int PIN_TRIG_TWO = 1;
  localparam int PIN_KEYING = 2;
  localparam int PIN_MULTIPURPOSE_OUT_PIN = 3;
  // Pin control layout: drive state in [2:0], select in [8:3]
  localparam int CTL_W = 9;
  localparam int DRV_LSB = 0;
  localparam int SEL_LSB = 3;
  localparam int SEL_W = 6;
  localparam logic [8:0] CTL_RST_TRIG_ONE = 9'h008;
  localparam logic [8:0] CTL_RST_TRIG_TWO = 9'h010;
  localparam logic [8:0] CTL_RST_KEYING = 9'h018;
  localparam logic [8:0] CTL_RST_MULTIPURPOSE_OUT_PIN = 9'h038;
  // Threshold layout: low in [5:0], high in [13:8]
  localparam int THR_W = 6;
  localparam int THR_LO_LSB = 0;
  localparam int THR_HI_LSB = 8;
  localparam logic [5:0] THR_LO_RST = 6'h0A;
  localparam logic [5:0] THR_HI_RST = 6'h32;
  // Drive-state codes
  localparam logic [2:0] DRV_TRISTATE = 3'h0;
  localparam logic [2:0] DRV_OPEN_DRAIN = 3'h1;
  localparam logic [2:0] DRV_PUSH_PULL = 3'h2;
  localparam logic [2:0] DRV_RESERVED = 3'h3;
  localparam logic [2:0] DRV_GROUND = 3'h4;
  localparam logic [2:0] DRV_INV_OPEN_DRAIN = 3'h5;
  localparam logic [2:0] DRV_INV_PUSH_PULL = 3'h6;
  localparam logic [2:0] DRV_INPUT = 3'h7;
  // Selection codes
  localparam int SEL_OUT_TRIG_ONE = 4;
  localparam int SEL_OUT_TRIG_TWO = 5;
  localparam int SEL_OUT_KEYING = 6;
  localparam int SEL_READBACK = 7;
  localparam int SEL_COMPARATOR_ZERO = 8;
  localparam int SEL_COMPARATOR_ONE = 9;
  localparam int SEL_LOCK = 10;
  localparam int SEL_DLD = 11;
  localparam int SEL_MON_GOOD = 12;
  localparam int SEL_MON_HIGH = 13;
  localparam int SEL_MON_LOW = 14;
  localparam int SEL_RAMP_LIMIT = 15;
  localparam int SEL_RDIV2 = 16;
  localparam int SEL_RDIV4 = 17;
  localparam int SEL_NDIV2 = 18;
  localparam int SEL_NDIV4 = 19;
  localparam int SEL_COMPARATOR_ZERO_RAMP = 22;
  localparam int SEL_COMPARATOR_ONE_RAMP = 23;
  localparam int SEL_FASTLOCK = 28;
  localparam int SEL_PUMP_GAIN = 29;
  localparam int SEL_FLAG0 = 30;
  localparam int SEL_FLAG1 = 31;
  localparam int SEL_TRIG_A = 32;
  localparam int SEL_TRIG_B = 33;
  localparam int SEL_TRIG_C = 34;
  localparam int SEL_RDIV = 35;
  localparam int SEL_PUMP_UP = 36;
  localparam int SEL_PUMP_DN = 37;
  localparam int SEL_CNT_DONE = 38;
  localparam int SEL_FIRST_RSV_HI = 39;
  // Interrupt status bits
  localparam int ST_LOCK_LOST = 0;
  localparam int ST_LOCK_GAINED = 1;
  localparam int ST_PUMP_LOW = 2;
  localparam int ST_PUMP_HIGH = 3;
  localparam int ST_W = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** pin_mux_props.sv ***
/*
  Checker for the pin mux top; watches its ports only.
  Assumes the low threshold is never set below its reset value.
*/
`timescale 1ns/100ps
module pin_mux_props
  import pin_mux_pkg::*;
#(
  parameter int PUMP_W = 6
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Bus handshakes
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  // Lock and pads
  input wire logic digital_phase_lock_i,
  input wire logic [PUMP_W-1:0] pump_voltage_monitor_i,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] pin_oe_o,
  input wire logic [NUM_PINS-1:0] synced_pin_o,
  input wire logic combined_lock_indication_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Write: both halves taken, then the response within two edges
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_wr_answer;
    ##[1:2] s_axi_bvalid_o;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> s_wr_answer;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_wr_refused;
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write accepted while answering");
  property p_rd_answer;
    s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  property p_rd_refused;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("read accepted while answering");
  // Two flops between pad and internal view
  property p_sync;
    $past(reset_n_i) && $past(reset_n_i, 2) |-> synced_pin_o == $past(pin_in_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser depth wrong");
  property p_reset_state;
    $rose(reset_n_i) |-> pin_oe_o == '0 && !combined_lock_indication_o && s_axi_awready_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("pads not released after reset");
  property p_lock_dld;
    combined_lock_indication_o |-> $past(digital_phase_lock_i);
  endproperty
  a_lock_dld: assert property (p_lock_dld) else $error("lock without phase lock");
  property p_lock_low;
    $past(pump_voltage_monitor_i) < THR_LO_RST |-> !combined_lock_indication_o;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock with pump voltage low");
endmodule

bind pin_mux pin_mux_props #(.PUMP_W(PUMP_W)) u_props (.clk_i, .reset_n_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .digital_phase_lock_i, .pump_voltage_monitor_i, .pin_in_i,
  .pin_oe_o, .synced_pin_o, .combined_lock_indication_o);

// *** tb.sv ***
/*
  Self-checking bench for the pin mux: registers, routing, drive states,
  synchroniser, lock and interrupt. Assumes the board model pulls pads high.
*/
`timescale 1ns/100ps
module tb;
  import pin_mux_pkg::*;
  logic clk_i, reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, digital_phase_lock_i, combined_lock_indication_o, irq_o, probe;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed, probe_mask, view;
  logic [3:0] s_axi_wstrb_i, pin_in_i, pin_out_o, pin_oe_o, synced_pin_o, ext_val;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, p;
  logic [5:0] pump_voltage_monitor_i;
  logic [20:0] src;
  logic [31:0] note_q[$];
  int fails, check_count, cycles;
  assign view = {18'h0, irq_o, combined_lock_indication_o, synced_pin_o, pin_oe_o, pin_out_o};

  pin_mux dut (.clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .digital_phase_lock_i, .pump_voltage_monitor_i, .readback_data_i(src[0]),
    .comparator_zero_i(src[1]), .comparator_one_i(src[2]), .ramp_limit_exceeded_i(src[3]),
    .ref_div_half_i(src[4]), .ref_div_quarter_i(src[5]), .fb_div_half_i(src[6]), .fb_div_quarter_i(src[7]),
    .comparator_zero_ramp_i(src[8]), .comparator_one_ramp_i(src[9]), .fastlock_active_i(src[10]),
    .pump_gain_select_i(src[11]), .ramp_flag_zero_i(src[12]), .ramp_flag_one_i(src[13]),
    .trigger_source_a_i(src[14]), .trigger_source_b_i(src[15]), .trigger_source_c_i(src[16]),
    .ref_div_out_i(src[17]), .pump_up_pulse_i(src[18]), .pump_down_pulse_i(src[19]),
    .sweep_repeat_counter_done_i(src[20]), .pin_in_i, .pin_out_o, .pin_oe_o, .synced_pin_o,
    .combined_lock_indication_o, .irq_o);
  pad_board board (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_en_i(4'h7), .ext_val_i(ext_val),
    .pad_o(pin_in_i));

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Takes the oldest note whenever a result shows up; cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (s_axi_bvalid_o && s_axi_bready_i) check({30'h0, s_axi_bresp_o}, note_q.pop_front());
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      check(s_axi_rdata_o, note_q.pop_front());
      check({30'h0, s_axi_rresp_o}, note_q.pop_front());
    end
    if (probe) check(view & probe_mask, note_q.pop_front());
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] resp);
    bit a;
    bit w;
    note_q.push_back({30'h0, resp});
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= 4'hF;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    a = 1;
    w = 1;
    while (a || w) begin
      @(posedge clk_i);
      if (a && s_axi_awready_o) begin
        a = 0;
        s_axi_awvalid_i <= 1'b0;
      end
      if (w && s_axi_wready_o) begin
        w = 0;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    do @(posedge clk_i); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] resp);
    note_q.push_back(d);
    note_q.push_back({30'h0, resp});
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Let the longest path (pad, two flops, pin register) settle, then look once
  task automatic expect_view(input logic [31:0] m, input logic [31:0] v);
    repeat (4) @(posedge clk_i);
    probe_mask <= m;
    probe <= 1'b1;
    note_q.push_back(v & m);
    @(posedge clk_i);
    probe <= 1'b0;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Expected routed value: sources sit in seed[20:0], lock in 21, pump code in 27:22
  function automatic logic route(input int sel, input logic [31:0] w);
    logic lo;
    logic hi;
    lo = w[27:22] < THR_LO_RST;
    hi = w[27:22] > THR_HI_RST;
    case (sel) inside
      [4:6]: return w[sel + 24];
      7: return w[0];
      8, 9: return w[sel - 7];
      10: return w[21] & !lo & !hi;
      11: return w[21];
      12: return !lo & !hi;
      13: return hi;
      14: return lo;
      [15:19]: return w[sel - 12];
      22, 23: return w[sel - 14];
      [28:38]: return w[sel - 18];
      default: return 1'b0;
    endcase
  endfunction

  // Pad pair {oe, out}; a reserved drive code, or a reserved select outside codes 0 and 7, pulls the pad low
  function automatic logic [1:0] pad(input logic [2:0] d, input logic v, input logic r);
    case (d)
      3'h0, 3'h7: return 2'b00;
      3'h1: return r ? 2'b10 : {!v, 1'b0};
      3'h2: return r ? 2'b10 : {1'b1, v};
      3'h5: return r ? 2'b10 : {v, 1'b0};
      3'h6: return r ? 2'b10 : {1'b1, !v};
      default: return 2'b10;
    endcase
  endfunction

  // Main sequence
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, probe} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i, probe_mask, ext_val} = '0;
    {digital_phase_lock_i, pump_voltage_monitor_i, src} = '0;
    reset_n_i = 1'b0;
    seed = 32'hBEC7967B;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(IDX_TRIG_ONE_CTL, 32'(CTL_RST_TRIG_ONE), RESP_OKAY);
    rd(IDX_TRIG_TWO_CTL, 32'(CTL_RST_TRIG_TWO), RESP_OKAY);
    rd(IDX_KEYING_CTL, 32'(CTL_RST_KEYING), RESP_OKAY);
    rd(IDX_MULTIPURPOSE_OUT_PIN_CTL, 32'(CTL_RST_MULTIPURPOSE_OUT_PIN), RESP_OKAY);
    rd(IDX_THRESHOLD, {18'h0, THR_HI_RST, 2'h0, THR_LO_RST}, RESP_OKAY);
    rd(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(6'h00, 32'h0, RESP_SLVERR);
    wr(6'h3F, 32'h1, RESP_SLVERR);
    wr(IDX_TRIG_TWO_CTL, 32'hFFFFFE10, RESP_OKAY);
    rd(IDX_TRIG_TWO_CTL, 32'h00000010, RESP_OKAY);
    $display("register test done");
    for (int d = 0; d < 8; d++) begin
      for (int s = 0; s < 64; s++) begin
        seed = xs(seed);
        src <= seed[20:0];
        digital_phase_lock_i <= seed[21];
        pump_voltage_monitor_i <= seed[27:22];
        ext_val <= {1'b0, seed[30:28]};
        wr(IDX_MULTIPURPOSE_OUT_PIN_CTL, 32'(s * 8 + d), RESP_OKAY);
        p = pad(3'(d), route(s, seed), s inside {20, 21, [24:27]} || s >= 39);
        expect_view((d == 0 || d == 7) ? 32'h17F7 : 32'h17FF,
          {19'h0, route(10, seed), 1'b0, seed[30:28], p[1], 3'h0, p[0], 3'h0});
      end
    end
    $display("routing test done");
    digital_phase_lock_i <= 1'b0;
    pump_voltage_monitor_i <= 6'h20;
    wr(IDX_IRQ_STATUS, 32'hF, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 32'h0, RESP_OKAY);
    wr(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
    digital_phase_lock_i <= 1'b1;
    expect_view(32'h3000, 32'h3000);
    rd(IDX_IRQ_STATUS, 32'h2, RESP_OKAY);
    wr(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
    expect_view(32'h2000, 32'h0);
    wr(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 32'h2, RESP_OKAY);
    expect_view(32'h2000, 32'h0);
    pump_voltage_monitor_i <= 6'h00;
    expect_view(32'h1000, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h5, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 32'h5, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 32'h4, RESP_OKAY);
    wr(IDX_THRESHOLD, 32'h3F30, RESP_OKAY);
    rd(IDX_THRESHOLD, 32'h3F30, RESP_OKAY);
    pump_voltage_monitor_i <= 6'h20;
    expect_view(32'h1000, 32'h0);
    pump_voltage_monitor_i <= 6'h38;
    expect_view(32'h1000, 32'h1000);
    $display("interrupt test done");
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(IDX_MULTIPURPOSE_OUT_PIN_CTL, 32'(CTL_RST_MULTIPURPOSE_OUT_PIN), RESP_OKAY);
    rd(IDX_THRESHOLD, {18'h0, THR_HI_RST, 2'h0, THR_LO_RST}, RESP_OKAY);
    $display("second reset test done");
    results();
  end
endmodule
